// File: design/rcap_pkg.sv
// Constants and types shared by the reset sequencer and attribute access port.
//
// What this block does
// - Fundamental reset input is asynchronous, active low, asserted in platform fundamental reset.
// - While fundamental reset is low, core hard reset is asserted; the attribute store and port keep running.
// - After fundamental reset release the device starts link training, then runs normally.
// - In-band hot reset bypasses fundamental reset and raises the in-band reset flag.
// - User-side reset output is released synchronously to the user-side clock.
// - User-side reset asserts on fundamental reset, wrapper PLL or transceiver PLL unlock.
// - User-side reset stays asserted until all causes clear, then link retrains.
// - Attribute port is synchronous: address, separate data buses, enable, write enable, ready.
// - Ready marks a completed write or valid read data.
// - Attribute reads are served whatever the fundamental reset state.
// - Attribute port has a 9-bit address and 16-bit read and write data.

package rcap_pkg;

    // ==========================================================
    // Clock and reference clock figures
    // ==========================================================
    localparam int CLK_PERIOD_NS = 25;
    localparam int REFCLK_MHZ_100 = 100;
    localparam int REFCLK_MHZ_125 = 125;
    localparam int REFCLK_MHZ_250 = 250;

    // ==========================================================
    // Attribute port geometry
    // ==========================================================
    localparam int ATTR_ADDR_W = 9;
    localparam int ATTR_DATA_W = 16;
    localparam int ATTR_WORDS = 81;
    localparam logic [8:0] ATTR_LAST_ADDR = 9'h050;
    localparam logic [15:0] ATTR_RESET_VAL = 16'h0000;
    localparam logic [15:0] ATTR_UNMAPPED_VAL = 16'h0000;

    // Cycles from taking an access to its completion edge
    localparam logic [1:0] CFG_ACCESS_CYCLES = 2'h2;

    // ==========================================================
    // Transceiver count and synchroniser reset values
    // ==========================================================
    localparam int XCVR_LANES = 8;
    localparam logic SYNC_RST_VAL = 1'b0;
    localparam logic [XCVR_LANES+1:0] LVL_SYNC_RST_VAL = {(XCVR_LANES+2){1'b0}};

    // ==========================================================
    // Link sequencing states
    // ==========================================================
    typedef enum logic [1:0] {
        LS_RESET  = 2'b00,
        LS_TRAIN  = 2'b01,
        LS_ACTIVE = 2'b10,
        LS_HOT    = 2'b11
    } rcap_link_state_t;

    // ==========================================================
    // Attribute port carriers
    // ==========================================================
    typedef struct packed {
        logic cfgport_enable;
        logic cfgport_write_enable;
        logic [ATTR_ADDR_W-1:0] cfgport_address;
        logic [ATTR_DATA_W-1:0] cfgport_write_data;
    } rcap_cfg_req_t;

    typedef struct packed {
        logic cfgport_ready;
        logic [ATTR_DATA_W-1:0] cfgport_read_data;
    } rcap_cfg_rsp_t;

    // ==========================================================
    // Whole state of the top module
    // ==========================================================
    typedef struct packed {
        logic [ATTR_WORDS-1:0][ATTR_DATA_W-1:0] attr;
        rcap_link_state_t lstate;
        logic user_rst_n;
        logic hot_flag;
        logic train_pulse;
        logic busy;
        logic [1:0] cnt;
        logic pend_we;
        logic [ATTR_ADDR_W-1:0] pend_addr;
        logic [ATTR_DATA_W-1:0] pend_wdata;
        logic ready;
        logic [ATTR_DATA_W-1:0] rdata;
    } rcap_state_t;

endpackage

// File: design/rcap_sync.sv
// Two-flop synchroniser with asynchronous clear to a constant.
`timescale 1ns/1ps

module rcap_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and clear
    input wire logic clk_i,
    input wire logic arst_b_i,
    // Data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    // ==========================================================
    // Synchroniser stages
    // ==========================================================
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i or negedge arst_b_i)
    begin
        if (!arst_b_i)
        begin
            meta_q <= RST_VAL;
            q_o <= RST_VAL;
        end
        else
        begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end

endmodule

// File: design/rcap_top.sv
// Reset sequencer, link start control and attribute access port of the endpoint block.
`timescale 1ns/1ps

module rcap_top (
    // Clock and power-on reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Fundamental reset pin and lock indications
    input wire logic fund_reset_n_i,
    input wire logic wrapper_pll_lock_i,
    input wire logic [rcap_pkg::XCVR_LANES-1:0] xcvr_pll_lock_i,
    // Link side
    input wire logic hot_reset_rx_i,
    input wire logic link_up_i,
    output logic core_hard_reset_o,
    output logic link_train_start_o,
    output rcap_pkg::rcap_link_state_t link_state_o,
    // User side reset and flags
    output logic user_side_reset_out_n_o,
    output logic inband_link_reset_flag_o,
    // Attribute access port
    input wire rcap_pkg::rcap_cfg_req_t cfg_req_i,
    output rcap_pkg::rcap_cfg_rsp_t cfg_rsp_o
);

    // ==========================================================
    // Decoding helpers
    // ==========================================================

    // Address lies inside the populated attribute window
    function automatic logic attr_mapped(input logic [rcap_pkg::ATTR_ADDR_W-1:0] addr);
        attr_mapped = (addr <= rcap_pkg::ATTR_LAST_ADDR);
    endfunction

    // Read word at an address, fixed value for holes
    function automatic logic [rcap_pkg::ATTR_DATA_W-1:0] attr_read(
        input logic [rcap_pkg::ATTR_WORDS-1:0][rcap_pkg::ATTR_DATA_W-1:0] mem,
        input logic [rcap_pkg::ATTR_ADDR_W-1:0] addr);
        if (attr_mapped(addr))
            attr_read = mem[addr];
        else
            attr_read = rcap_pkg::ATTR_UNMAPPED_VAL;
    endfunction

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic fund_arst_b;
    logic fund_ok;
    logic [rcap_pkg::XCVR_LANES+1:0] lvl_raw;
    logic [rcap_pkg::XCVR_LANES+1:0] lvl_s;
    logic wrap_lock_s;
    logic [rcap_pkg::XCVR_LANES-1:0] xcvr_lock_s;
    logic hot_s;

    // Pin clears at once, release is seen two edges later
    assign fund_arst_b = rst_b_i & fund_reset_n_i;

    rcap_sync #(
        .WIDTH(1),
        .RST_VAL(rcap_pkg::SYNC_RST_VAL)
    ) u_fund_sync (
        .clk_i(ref_clk_i),
        .arst_b_i(fund_arst_b),
        .d_i(1'b1),
        .q_o(fund_ok)
    );

    // Lock and hot reset levels come from other clock domains
    assign lvl_raw = {hot_reset_rx_i, wrapper_pll_lock_i, xcvr_pll_lock_i};

    rcap_sync #(
        .WIDTH(rcap_pkg::XCVR_LANES + 2),
        .RST_VAL(rcap_pkg::LVL_SYNC_RST_VAL)
    ) u_lvl_sync (
        .clk_i(ref_clk_i),
        .arst_b_i(rst_b_i),
        .d_i(lvl_raw),
        .q_o(lvl_s)
    );

    assign hot_s = lvl_s[rcap_pkg::XCVR_LANES+1];
    assign wrap_lock_s = lvl_s[rcap_pkg::XCVR_LANES];
    assign xcvr_lock_s = lvl_s[rcap_pkg::XCVR_LANES-1:0];

    // ==========================================================
    // State registers
    // ==========================================================
    rcap_pkg::rcap_state_t q;
    rcap_pkg::rcap_state_t d;
    logic cause_any;
    logic acc_take;
    logic acc_done;

    // Any reason to hold the user side in reset
    assign cause_any = !fund_ok || !wrap_lock_s || !(&xcvr_lock_s);

    // New access only when idle; enable while busy is dropped
    assign acc_take = cfg_req_i.cfgport_enable && !q.busy;
    assign acc_done = q.busy && (q.cnt == 2'h0);

    // Next-state logic for the whole block
    always_comb
    begin
        d = q;
        d.train_pulse = 1'b0;
        d.ready = 1'b0;

        // User reset: assert on any cause, release only when all clear
        d.user_rst_n = !cause_any;

        // Link sequencing
        case (q.lstate)
            rcap_pkg::LS_RESET:
            begin
                if (!cause_any)
                begin
                    d.lstate = rcap_pkg::LS_TRAIN;
                    d.train_pulse = 1'b1;
                end
            end
            rcap_pkg::LS_TRAIN:
            begin
                if (hot_s)
                    d.lstate = rcap_pkg::LS_HOT;
                else if (link_up_i)
                    d.lstate = rcap_pkg::LS_ACTIVE;
            end
            rcap_pkg::LS_ACTIVE:
            begin
                if (hot_s)
                    d.lstate = rcap_pkg::LS_HOT;
                else if (!link_up_i)
                begin
                    d.lstate = rcap_pkg::LS_TRAIN;
                    d.train_pulse = 1'b1;
                end
            end
            rcap_pkg::LS_HOT:
            begin
                // Retrain once the in-band reset has gone away
                if (!hot_s)
                begin
                    d.lstate = rcap_pkg::LS_TRAIN;
                    d.train_pulse = 1'b1;
                end
            end
            default:
            begin
                d.lstate = rcap_pkg::LS_RESET;
            end
        endcase

        // Any cause overrides sequencing: hold training off
        if (cause_any)
        begin
            d.lstate = rcap_pkg::LS_RESET;
            d.train_pulse = 1'b0;
        end

        // In-band reset flag follows the hot reset, gated off while the pin holds reset
        d.hot_flag = hot_s && fund_ok;

        // Attribute port: accept, count down, complete
        if (acc_take)
        begin
            d.busy = 1'b1;
            d.cnt = rcap_pkg::CFG_ACCESS_CYCLES - 2'h1;
            d.pend_we = cfg_req_i.cfgport_write_enable;
            d.pend_addr = cfg_req_i.cfgport_address;
            d.pend_wdata = cfg_req_i.cfgport_write_data;
        end
        else if (acc_done)
        begin
            d.busy = 1'b0;
            d.ready = 1'b1;
            if (q.pend_we)
            begin
                // Writes land only under fundamental reset; others are dropped
                if (!fund_ok && attr_mapped(q.pend_addr))
                    d.attr[q.pend_addr] = q.pend_wdata;
            end
            else
            begin
                d.rdata = attr_read(q.attr, q.pend_addr);
            end
        end
        else if (q.busy)
        begin
            d.cnt = q.cnt - 2'h1;
        end
    end

    // Single register for all state; the attribute store survives fund reset
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            q.attr <= {rcap_pkg::ATTR_WORDS{rcap_pkg::ATTR_RESET_VAL}};
            q.lstate <= rcap_pkg::LS_RESET;
            q.user_rst_n <= 1'b0;
            q.hot_flag <= 1'b0;
            q.train_pulse <= 1'b0;
            q.busy <= 1'b0;
            q.cnt <= 2'h0;
            q.pend_we <= 1'b0;
            q.pend_addr <= 9'h000;
            q.pend_wdata <= 16'h0000;
            q.ready <= 1'b0;
            q.rdata <= 16'h0000;
        end
        else
        begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================

    // Assertion is immediate through fund_ok, release waits for a clock edge
    assign user_side_reset_out_n_o = q.user_rst_n & fund_ok;
    assign core_hard_reset_o = !fund_ok;
    assign link_train_start_o = q.train_pulse;
    assign link_state_o = q.lstate;
    assign inband_link_reset_flag_o = q.hot_flag;
    assign cfg_rsp_o.cfgport_ready = q.ready;
    assign cfg_rsp_o.cfgport_read_data = q.rdata;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence acc_taken_s;
        acc_take;
    endsequence

    sequence ready_after_s;
        ##3 cfg_rsp_o.cfgport_ready;
    endsequence

    fund_hold_a: assert property (!fund_ok |=> q.lstate == rcap_pkg::LS_RESET)
        else $error("link state left reset while fundamental reset held");

    urst_cause_a: assert property (cause_any |=> !user_side_reset_out_n_o)
        else $error("user reset not asserted after a reset cause");

    urst_release_a: assert property ($rose(user_side_reset_out_n_o) |->
        !$past(cause_any) && fund_ok)
        else $error("user reset released while a cause was present");

    urst_sync_a: assert property (!cause_any && !user_side_reset_out_n_o && fund_ok
        |=> user_side_reset_out_n_o || cause_any)
        else $error("user reset release not taken on the next edge");

    train_start_a: assert property (q.lstate == rcap_pkg::LS_RESET && !cause_any
        |=> link_train_start_o && q.lstate == rcap_pkg::LS_TRAIN)
        else $error("training not started after reset causes cleared");

    hot_flag_a: assert property (hot_s && fund_ok |=> inband_link_reset_flag_o)
        else $error("in-band reset flag missing during hot reset");

    ready_lat_a: assert property (acc_taken_s |-> ready_after_s)
        else $error("ready not given three cycles after an access");

    ready_pulse_a: assert property (cfg_rsp_o.cfgport_ready |=>
        !cfg_rsp_o.cfgport_ready)
        else $error("ready held longer than one cycle");

    busy_ignore_a: assert property (cfg_req_i.cfgport_enable && q.busy && q.cnt != 2'h0
        |=> $stable(q.pend_addr) && $stable(q.pend_we))
        else $error("access captured while another was outstanding");

    // Word the request on the port would read, kept as a signal for the read check
    logic [rcap_pkg::ATTR_DATA_W-1:0] rd_word;
    assign rd_word = attr_read(q.attr, cfg_req_i.cfgport_address);

    read_data_a: assert property (acc_taken_s and !cfg_req_i.cfgport_write_enable
        |-> ##3 cfg_rsp_o.cfgport_read_data == $past(rd_word, 3))
        else $error("read data does not match the stored attribute");

    write_lock_a: assert property (acc_done && q.pend_we && fund_ok
        |=> q.attr == $past(q.attr))
        else $error("attribute changed by a write outside fundamental reset");

    // ==========================================================
    // Further reset and link checks
    // ==========================================================

    // Pin low must reach the outputs without waiting for a clock edge
    pin_reset_a: assert property (!fund_reset_n_i |->
        core_hard_reset_o && !user_side_reset_out_n_o)
        else $error("fundamental reset pin low but outputs not in reset");

    // Train start is a strobe, never a level
    train_pulse_a: assert property (link_train_start_o |=> !link_train_start_o)
        else $error("training start held longer than one cycle");

    // Training stays off while any cause remains
    train_hold_a: assert property (cause_any |=> !link_train_start_o)
        else $error("training started while a reset cause was present");

    // In-band reset moves a training or active link into the hot state
    hot_enter_a: assert property (hot_s && !cause_any &&
        (q.lstate == rcap_pkg::LS_TRAIN || q.lstate == rcap_pkg::LS_ACTIVE)
        |=> q.lstate == rcap_pkg::LS_HOT)
        else $error("hot reset did not move the link to the hot state");

    // Flag drops once the in-band reset has gone
    hot_clear_a: assert property (!hot_s |=> !inband_link_reset_flag_o)
        else $error("in-band reset flag still set after hot reset ended");

    // Hot reset alone never pulls the user reset
    hot_urst_a: assert property (user_side_reset_out_n_o && !cause_any
        |=> user_side_reset_out_n_o || cause_any)
        else $error("user reset asserted without a reset cause");

    // ==========================================================
    // Further attribute port checks
    // ==========================================================

    // A write under fundamental reset lands in the addressed word
    write_land_a: assert property (acc_done && q.pend_we && !fund_ok &&
        attr_mapped(q.pend_addr) |=> q.attr[q.pend_addr] == q.pend_wdata)
        else $error("write under fundamental reset did not land");

    // Holes above the populated window read back as the fixed value
    hole_read_a: assert property (acc_done && !q.pend_we && !attr_mapped(q.pend_addr)
        |=> cfg_rsp_o.cfgport_read_data == rcap_pkg::ATTR_UNMAPPED_VAL)
        else $error("read of an unpopulated address returned data");

    // Read data stands until the next read completes
    rdata_hold_a: assert property (!(acc_done && !q.pend_we)
        |=> $stable(cfg_rsp_o.cfgport_read_data))
        else $error("read data changed without a completed read");

    // Ready only ends an access, so the port is idle while it stands
    ready_idle_a: assert property (cfg_rsp_o.cfgport_ready |-> !q.busy)
        else $error("ready raised while an access was still outstanding");

endmodule

// File: testbench/rcap_user_model.sv
// User-side master model of the attribute access port.
`timescale 1ns/1ps

module rcap_user_model (
    // Clock
    input wire logic clk_i,
    // Attribute port
    output rcap_pkg::rcap_cfg_req_t req_o,
    input wire rcap_pkg::rcap_cfg_rsp_t rsp_i
);
    // ==========================================================
    // Idle request at time zero
    // ==========================================================
    initial
    begin
        req_o = '0;
    end

    // One access; en_cycles of 2 overlaps the busy window on purpose.
    // Every ready in a fixed window is counted, so a double pulse shows.
    task automatic access(input logic we, input logic [8:0] addr,
        input logic [15:0] wdata, input int en_cycles,
        output int lat, output int n_rdy, output logic [15:0] rdata);
        lat = 0;
        n_rdy = 0;
        rdata = '0;
        @(posedge clk_i);
        req_o.cfgport_enable <= 1'b1;
        req_o.cfgport_write_enable <= we;
        req_o.cfgport_address <= addr;
        req_o.cfgport_write_data <= wdata;
        for (int i = 1; i <= 8; i++)
        begin
            @(posedge clk_i);
            // Released bus shows no stale value
            if (i == en_cycles)
            begin
                req_o.cfgport_enable <= 1'b0;
                req_o.cfgport_address <= ~addr;
                req_o.cfgport_write_data <= ~wdata;
            end
            if (rsp_i.cfgport_ready === 1'b1)
            begin
                n_rdy++;
                if (lat == 0)
                begin
                    lat = i - 1;
                    rdata = rsp_i.cfgport_read_data;
                end
            end
        end
    endtask
endmodule

// File: testbench/rcap_top_tb.sv
// Self-checking testbench of the reset sequencer and attribute port.
`timescale 1ns/1ps

`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

module rcap_top_tb;
    // ==========================================================
    // Signals
    // ==========================================================
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic fund_reset_n_i = 1'b0;
    logic wrapper_pll_lock_i = 1'b1;
    logic [rcap_pkg::XCVR_LANES-1:0] xcvr_pll_lock_i = '1;
    logic hot_reset_rx_i = 1'b0;
    logic link_up_i = 1'b0;
    logic core_hard_reset_o;
    logic link_train_start_o;
    rcap_pkg::rcap_link_state_t link_state_o;
    logic user_side_reset_out_n_o;
    logic inband_link_reset_flag_o;
    rcap_pkg::rcap_cfg_req_t cfg_req_i;
    rcap_pkg::rcap_cfg_rsp_t cfg_rsp_o;
    int mismatches = 0;
    int n_checks = 0;

    rcap_top u_dut (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .fund_reset_n_i(fund_reset_n_i),
        .wrapper_pll_lock_i(wrapper_pll_lock_i), .xcvr_pll_lock_i(xcvr_pll_lock_i),
        .hot_reset_rx_i(hot_reset_rx_i), .link_up_i(link_up_i),
        .core_hard_reset_o(core_hard_reset_o), .link_train_start_o(link_train_start_o),
        .link_state_o(link_state_o), .user_side_reset_out_n_o(user_side_reset_out_n_o),
        .inband_link_reset_flag_o(inband_link_reset_flag_o),
        .cfg_req_i(cfg_req_i), .cfg_rsp_o(cfg_rsp_o)
    );

    rcap_user_model u_usr (.clk_i(ref_clk_i), .req_o(cfg_req_i), .rsp_i(cfg_rsp_o));

    // Clock generation, 25 ns period; only the block clock is made here.
    // Link reference clock at its generated rate, its sharing for link power
    // management and the slot clock setting stay system matters
    initial
    begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic end_of_test();
        if (mismatches == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One access with latency, single-ready and read data checks
    task automatic cfg(input logic we, input logic [8:0] a, input logic [15:0] d,
        input int en, input logic [15:0] exp);
        int lat;
        int nr;
        logic [15:0] rd;
        u_usr.access(we, a, d, en, lat, nr, rd);
        `CHK(lat, 3)
        `CHK(nr, 1)
        if (!we)
            `CHK(rd, exp)
        if (nr == 0)
            end_of_test();
    endtask

    // Edges until user reset reaches lvl; train pulse seen at that point
    task automatic wait_rst(input logic lvl, output int n, output logic pulse);
        n = 99;
        pulse = 1'b0;
        for (int i = 1; i <= 12; i++)
        begin
            @(posedge ref_clk_i);
            #1;
            if (user_side_reset_out_n_o === lvl)
            begin
                n = i;
                pulse = link_train_start_o;
                break;
            end
        end
        if (n == 99)
        begin
            mismatches++;
            end_of_test();
        end
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    // Attribute store written only while the pin holds reset
    task automatic t_attr();
        `CHK(core_hard_reset_o, 1'b1)
        `CHK(user_side_reset_out_n_o, 1'b0)
        `CHK(link_state_o, rcap_pkg::LS_RESET)
        // Words used here hold no payload, buffer or RAM latency setting
        cfg(1'b1, 9'h005, 16'hA5C3, 1, 16'h0000);
        cfg(1'b1, 9'h006, 16'h3C5A, 1, 16'h0000);
        cfg(1'b1, 9'h050, 16'h1234, 2, 16'h0000);
        cfg(1'b1, 9'h051, 16'hBEEF, 1, 16'h0000);
        cfg(1'b0, 9'h005, 16'h0000, 1, 16'hA5C3);
        cfg(1'b0, 9'h006, 16'h0000, 2, 16'h3C5A);
        cfg(1'b0, 9'h050, 16'h0000, 1, 16'h1234);
        // Read-modify-write: keep the upper byte just read, change the lower one
        cfg(1'b1, 9'h050, (16'h1234 & 16'hFF00) | 16'h0077, 1, 16'h0000);
        cfg(1'b0, 9'h050, 16'h0000, 1, 16'h1277);
        cfg(1'b0, 9'h051, 16'h0000, 1, rcap_pkg::ATTR_UNMAPPED_VAL);
    endtask

    // Pin release starts training; writes afterwards are dropped
    task automatic t_release();
        int n;
        logic p;
        @(posedge ref_clk_i);
        fund_reset_n_i <= 1'b1;
        wait_rst(1'b1, n, p);
        `CHK(n, 3)
        `CHK(p, 1'b1)
        `CHK(link_state_o, rcap_pkg::LS_TRAIN)
        `CHK(core_hard_reset_o, 1'b0)
        @(posedge ref_clk_i);
        link_up_i <= 1'b1;
        #1;
        `CHK(link_train_start_o, 1'b0)
        @(posedge ref_clk_i);
        #1;
        `CHK(link_state_o, rcap_pkg::LS_ACTIVE)
        cfg(1'b1, 9'h005, 16'hFFFF, 1, 16'h0000);
        cfg(1'b0, 9'h005, 16'h0000, 1, 16'hA5C3);
    endtask

    // Each lock, wrapper last, forces user reset and retrain
    task automatic t_locks();
        int n;
        logic p;
        for (int k = 0; k <= rcap_pkg::XCVR_LANES; k++)
        begin
            @(posedge ref_clk_i);
            if (k == rcap_pkg::XCVR_LANES)
                wrapper_pll_lock_i <= 1'b0;
            else
                xcvr_pll_lock_i[k] <= 1'b0;
            wait_rst(1'b0, n, p);
            `CHK(n, 3)
            @(posedge ref_clk_i);
            wrapper_pll_lock_i <= 1'b1;
            xcvr_pll_lock_i <= '1;
            wait_rst(1'b1, n, p);
            `CHK(n, 3)
            `CHK(p, 1'b1)
        end
        // Two causes; clearing one must not release
        @(posedge ref_clk_i);
        wrapper_pll_lock_i <= 1'b0;
        xcvr_pll_lock_i[7] <= 1'b0;
        wait_rst(1'b0, n, p);
        @(posedge ref_clk_i);
        wrapper_pll_lock_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        #1;
        `CHK(user_side_reset_out_n_o, 1'b0)
        @(posedge ref_clk_i);
        xcvr_pll_lock_i <= '1;
        wait_rst(1'b1, n, p);
        `CHK(n, 3)
    endtask

    // In-band hot reset flags only; user reset stays released
    task automatic t_hot();
        int n;
        logic p;
        repeat (2) @(posedge ref_clk_i);
        hot_reset_rx_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        #1;
        `CHK(inband_link_reset_flag_o, 1'b1)
        `CHK(user_side_reset_out_n_o, 1'b1)
        `CHK(link_state_o, rcap_pkg::LS_HOT)
        @(posedge ref_clk_i);
        hot_reset_rx_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #1;
        `CHK(inband_link_reset_flag_o, 1'b0)
        // Link loss from the active state retrains with a fresh pulse
        @(posedge ref_clk_i);
        link_up_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        `CHK(link_train_start_o, 1'b1)
        `CHK(link_state_o, rcap_pkg::LS_TRAIN)
        @(posedge ref_clk_i);
        link_up_i <= 1'b1;
    endtask

    // Pin assertion acts before the next clock edge
    task automatic t_fund_async();
        @(posedge ref_clk_i);
        fund_reset_n_i <= 1'b0;
        #2;
        `CHK(user_side_reset_out_n_o, 1'b0)
        `CHK(core_hard_reset_o, 1'b1)
        @(posedge ref_clk_i);
        #1;
        `CHK(link_state_o, rcap_pkg::LS_RESET)
        cfg(1'b0, 9'h006, 16'h0000, 1, 16'h3C5A);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial
    begin
        repeat (6) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        #1;
        t_attr();
        t_release();
        t_locks();
        t_hot();
        t_fund_async();
        end_of_test();
    end

    // Cuts a hang short
    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        mismatches++;
        end_of_test();
    end
endmodule
